// *** src/ppc_pkg.sv ***
// Notes on behaviour
// - Separate turn-on and turn-off input thresholds; off at least 4 V, on at most 16 V.
// - With a nonzero fault response, output undervoltage makes the channel hiccup, then resume when the fault clears.
// - Output overvoltage turns high side off, low side on until inside good window.
// - Dual mode: each channel has independent protection, unaffected by the other.
// - Two-phase mode: only first channel's OV/UV detectors monitored; both channels act on them together.
// - Power good high and flags cleared only inside the power-good-on window.
// - Power-good thresholds form symmetric windows mirrored about nominal.
// - Power good low at start-up, after faults, and when off or disabled.
// - At 150 C stop switching, gates low; restart with soft start at or below 130 C.
// - Per-rail over-temperature fault and warning limits versus external sensor.
// - Undervoltage response programmable by fault-response setting.
// - Scratchpad holds 14 bits of user data.
// - Scratchpad bit 0 selects short or long dead time.
// - Writing 1 to scratchpad bit 1 permanently locks parameters.
// - Channel select bits 7 and 0: 00 first, 01 second, 11 both.
// - Channel select value with bit 7 set, bit 0 clear is ignored entirely.
// - With both selected reads return first channel; read-only writes discarded.
// - Operation mode persists until a new command or control pin change.
// - Operation bit 7 enables conversion absent faults; 0 holds gates low; resets 0.
// - Margin field 00XX off, 0101/0110 low, 1001/1010 high, loads stored target.
// - Per-channel bit decides whether operation enable bit is honoured.
package ppc_pkg;
  localparam logic [7:0] CMD_CHANNEL_SELECT    = 8'h00;
  localparam logic [7:0] CMD_OPERATION_CONTROL = 8'h01;
  localparam logic [7:0] CMD_FAULT_RESPONSE    = 8'h47;
  localparam logic [7:0] CMD_OVERTEMP_FAULT_LIMIT    = 8'h4f;
  localparam logic [7:0] CMD_OVERTEMP_WARNING_LIMIT     = 8'h51;
  localparam logic [7:0] CMD_USER_SCRATCHPAD   = 8'hd0;
  localparam logic [7:0] SEL_WMASK             = 8'h81;
  localparam logic [7:0] OP_WMASK              = 8'hbc;
  localparam int         OP_ON_BIT             = 7;
  localparam int         SEL_ALL_BIT           = 7;
  localparam int         SEL_IDX_BIT           = 0;
  localparam int         SP_WIDTH              = 14;
  localparam int         SP_DEADTIME_BIT       = 0;
  localparam int         SP_LOCK_BIT           = 1;
  localparam int         INPUT_TURN_OFF_THRESHOLD_MIN_MV        = 4000;
  localparam int         INPUT_TURN_ON_THRESHOLD_MAX_MV         = 16000;
  localparam int         TSD_TRIP_C            = 150;
  localparam int         TSD_CLEAR_C           = 130;
  localparam int         HICCUP_NS             = 1000000;
  localparam int         CLK_NS                = 50;
  localparam int         HICCUP_CYC            = HICCUP_NS / CLK_NS;
  localparam logic [7:0] OT_FAULT_RST          = 8'h7d;
  localparam logic [7:0] OT_WARN_RST           = 8'h73;
  localparam logic [7:0] FAULT_RESP_RST        = 8'h00;
  localparam logic [1:0] MARGIN_OFF            = 2'h0;
  localparam logic [1:0] MARGIN_LOW            = 2'h1;
  localparam logic [1:0] MARGIN_HIGH           = 2'h2;
  typedef enum logic [1:0] {CH_OFF, CH_RUN, CH_HICCUP, CH_OVP} ppc_ch_e;
endpackage : ppc_pkg

// *** src/ppc_top.sv ***
`timescale 1ns/1ns
module ppc_top #(
  parameter int HICCUP_CYC = ppc_pkg::HICCUP_CYC,
  parameter int VW         = 16
) (
  input  wire logic          mclk,
  input  wire logic          nrst,
  input  wire logic          cmd_wr,
  input  wire logic          cmd_rd,
  input  wire logic [7:0]    cmd_code,
  input  wire logic [15:0]   cmd_wdata,
  output logic      [15:0]   cmd_rdata_q,
  input  wire logic          two_phase,
  input  wire logic [1:0]    channel_control_pin,
  input  wire logic [VW-1:0] input_voltage_mv,
  input  wire logic [VW-1:0] input_turn_on_threshold,
  input  wire logic [VW-1:0] input_turn_off_threshold,
  input  wire logic [1:0]    ov_detect,
  input  wire logic [1:0]    uv_detect,
  input  wire logic [1:0]    in_good_on_window,
  input  wire logic [1:0]    soft_start_done,
  input  wire logic [1:0]    honour_on_bit,
  input  wire logic [7:0]    junction_temp_c,
  input  wire logic [15:0]   temperature_sense_input,
  output logic      [1:0]    high_side_gate_q,
  output logic      [1:0]    low_side_gate_q,
  output logic      [1:0]    power_good_output_q,
  output logic      [3:0]    margin_select_q,
  output logic      [1:0]    ot_fault_q,
  output logic      [1:0]    ot_warn_q,
  output logic               dead_time_long_q,
  output logic               params_locked_q,
  output logic               thermal_shutdown_q,
  output logic               input_ok_q
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [1:0] pin_s1_q, pin_s2_q, ov_s1_q, ov_s2_q, uv_s1_q, uv_s2_q, pg_s1_q, pg_s2_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      ov_s1_q  <= '0;
      ov_s2_q  <= '0;
      uv_s1_q  <= '0;
      uv_s2_q  <= '0;
      pg_s1_q  <= '0;
      pg_s2_q  <= '0;
    end else begin
      pin_s1_q <= channel_control_pin;
      pin_s2_q <= pin_s1_q;
      ov_s1_q  <= ov_detect;
      ov_s2_q  <= ov_s1_q;
      uv_s1_q  <= uv_detect;
      uv_s2_q  <= uv_s1_q;
      pg_s1_q  <= in_good_on_window;
      pg_s2_q  <= pg_s1_q;
    end
  end

  // ****************************************
  // Command registers
  // ****************************************
  logic [7:0]         sel_q, sel_d;
  logic [7:0]         op_q [2];
  logic [7:0]         op_d [2];
  logic [7:0]         otf_q [2];
  logic [7:0]         otf_d [2];
  logic [7:0]         otw_q [2];
  logic [7:0]         otw_d [2];
  logic [7:0]         resp_q [2];
  logic [7:0]         resp_d [2];
  logic [ppc_pkg::SP_WIDTH-1:0] sp_q, sp_d;
  logic [15:0]        rdata_d;
  logic [1:0]         hit;

  always_comb begin
    sel_d = sel_q;
    sp_d  = sp_q;
    op_d  = op_q;
    otf_d = otf_q;
    otw_d = otw_q;
    resp_d = resp_q;
    hit[0] = !sel_q[ppc_pkg::SEL_IDX_BIT] || sel_q[ppc_pkg::SEL_ALL_BIT];
    hit[1] = sel_q[ppc_pkg::SEL_IDX_BIT];
    if (cmd_wr) begin
      if (cmd_code == ppc_pkg::CMD_CHANNEL_SELECT) begin
        if (!(cmd_wdata[7] && !cmd_wdata[0]))
          sel_d = cmd_wdata[7:0] & ppc_pkg::SEL_WMASK;
      end else if (cmd_code == ppc_pkg::CMD_USER_SCRATCHPAD) begin
        if (!params_locked_q)
          sp_d = cmd_wdata[ppc_pkg::SP_WIDTH-1:0];
      end else begin
        for (int c = 0; c < 2; c++) begin
          if (hit[c]) begin
            if (cmd_code == ppc_pkg::CMD_OPERATION_CONTROL)
              op_d[c] = cmd_wdata[7:0] & ppc_pkg::OP_WMASK;
            else if (cmd_code == ppc_pkg::CMD_OVERTEMP_FAULT_LIMIT && !params_locked_q)
              otf_d[c] = cmd_wdata[7:0];
            else if (cmd_code == ppc_pkg::CMD_OVERTEMP_WARNING_LIMIT && !params_locked_q)
              otw_d[c] = cmd_wdata[7:0];
            else if (cmd_code == ppc_pkg::CMD_FAULT_RESPONSE && !params_locked_q)
              resp_d[c] = cmd_wdata[7:0];
          end
        end
      end
    end
    // Reads of both channels answer for the first
    rdata_d = cmd_rdata_q;
    if (cmd_rd) begin
      if (cmd_code == ppc_pkg::CMD_CHANNEL_SELECT)
        rdata_d = {8'h00, sel_q};
      else if (cmd_code == ppc_pkg::CMD_OPERATION_CONTROL)
        rdata_d = {8'h00, op_q[sel_q[0] & ~sel_q[7]]};
      else if (cmd_code == ppc_pkg::CMD_OVERTEMP_FAULT_LIMIT)
        rdata_d = {8'h00, otf_q[sel_q[0] & ~sel_q[7]]};
      else if (cmd_code == ppc_pkg::CMD_OVERTEMP_WARNING_LIMIT)
        rdata_d = {8'h00, otw_q[sel_q[0] & ~sel_q[7]]};
      else if (cmd_code == ppc_pkg::CMD_FAULT_RESPONSE)
        rdata_d = {8'h00, resp_q[sel_q[0] & ~sel_q[7]]};
      else if (cmd_code == ppc_pkg::CMD_USER_SCRATCHPAD)
        rdata_d = {2'h0, sp_q};
      else
        rdata_d = 16'h0000;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sel_q       <= 8'h00;
      sp_q        <= '0;
      cmd_rdata_q <= 16'h0000;
      for (int c = 0; c < 2; c++) begin
        op_q[c]   <= 8'h00;
        otf_q[c]  <= ppc_pkg::OT_FAULT_RST;
        otw_q[c]  <= ppc_pkg::OT_WARN_RST;
        resp_q[c] <= ppc_pkg::FAULT_RESP_RST;
      end
    end else begin
      sel_q       <= sel_d;
      sp_q        <= sp_d;
      cmd_rdata_q <= rdata_d;
      op_q        <= op_d;
      otf_q       <= otf_d;
      otw_q       <= otw_d;
      resp_q      <= resp_d;
    end
  end

  // ****************************************
  // Channel protection
  // ****************************************
  ppc_pkg::ppc_ch_e st_q [2];
  ppc_pkg::ppc_ch_e st_d [2];
  logic [31:0] hic_q [2];
  logic [31:0] hic_d [2];
  logic        tsd_d, vin_d, lock_d;
  logic [1:0]  hs_d, ls_d, pg_d, en, ov_eff, uv_eff, otf_c, otw_c;
  logic [3:0]  mg_d;

  function automatic logic [1:0] margin_dec(input logic [3:0] f);
    if (f[3:2] == 2'b00) margin_dec = ppc_pkg::MARGIN_OFF;
    else if (f == 4'h5 || f == 4'h6) margin_dec = ppc_pkg::MARGIN_LOW;
    else if (f == 4'h9 || f == 4'ha) margin_dec = ppc_pkg::MARGIN_HIGH;
    else margin_dec = ppc_pkg::MARGIN_OFF;
  endfunction : margin_dec

  always_comb begin
    // Hysteresis: trip at 150, release only at or below 130
    tsd_d = thermal_shutdown_q;
    if (junction_temp_c >= 8'(ppc_pkg::TSD_TRIP_C)) tsd_d = 1'b1;
    else if (junction_temp_c <= 8'(ppc_pkg::TSD_CLEAR_C)) tsd_d = 1'b0;
    // Turn-off threshold floored at 4 V; turn-on needs input at or below 16 V
    vin_d = input_ok_q;
    if (input_voltage_mv >= input_turn_on_threshold &&
        input_voltage_mv <= VW'(ppc_pkg::INPUT_TURN_ON_THRESHOLD_MAX_MV)) vin_d = 1'b1;
    else if (input_voltage_mv < input_turn_off_threshold ||
             input_voltage_mv < VW'(ppc_pkg::INPUT_TURN_OFF_THRESHOLD_MIN_MV)) vin_d = 1'b0;
    lock_d = params_locked_q | sp_q[ppc_pkg::SP_LOCK_BIT];
    ov_eff = two_phase ? {2{ov_s2_q[0]}} : ov_s2_q;
    uv_eff = two_phase ? {2{uv_s2_q[0]}} : uv_s2_q;
    mg_d = '0;
    for (int c = 0; c < 2; c++) begin
      otf_c[c] = temperature_sense_input[8*c +: 8] >= otf_q[c];
      otw_c[c] = temperature_sense_input[8*c +: 8] >= otw_q[c];
      en[c] = pin_s2_q[c] && (!honour_on_bit[c] || op_q[c][ppc_pkg::OP_ON_BIT])
              && input_ok_q && !thermal_shutdown_q && !ot_fault_q[c];
      mg_d[2*c +: 2] = margin_dec(op_q[c][5:2]);
      st_d[c] = st_q[c];
      hic_d[c] = hic_q[c];
      hs_d[c] = 1'b0;
      ls_d[c] = 1'b0;
      pg_d[c] = 1'b0;
      case (st_q[c])
        ppc_pkg::CH_OFF: if (en[c]) st_d[c] = ppc_pkg::CH_RUN;
        ppc_pkg::CH_RUN: begin
          hs_d[c] = 1'b1;
          ls_d[c] = 1'b1;
          // Start-up keeps power good low until soft start ends
          pg_d[c] = soft_start_done[c] && pg_s2_q[c];
          if (!en[c]) st_d[c] = ppc_pkg::CH_OFF;
          else if (ov_eff[c]) st_d[c] = ppc_pkg::CH_OVP;
          else if (uv_eff[c]) begin
            // Response code zero means keep running
            if (resp_q[c] != 8'h00) begin
              st_d[c] = ppc_pkg::CH_HICCUP;
              hic_d[c] = 32'(HICCUP_CYC);
            end
          end
        end
        ppc_pkg::CH_HICCUP: begin
          if (hic_q[c] != 0) hic_d[c] = hic_q[c] - 32'd1;
          else if (!uv_eff[c]) st_d[c] = ppc_pkg::CH_OFF;
        end
        default: begin
          ls_d[c] = 1'b1;
          if (pg_s2_q[c]) st_d[c] = ppc_pkg::CH_OFF;
        end
      endcase
      if (thermal_shutdown_q) begin
        hs_d[c] = 1'b0;
        ls_d[c] = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      for (int c = 0; c < 2; c++) begin
        st_q[c]  <= ppc_pkg::CH_OFF;
        hic_q[c] <= '0;
      end
      high_side_gate_q    <= '0;
      low_side_gate_q     <= '0;
      power_good_output_q <= '0;
      margin_select_q     <= '0;
      ot_fault_q          <= '0;
      ot_warn_q           <= '0;
      dead_time_long_q    <= 1'b0;
      params_locked_q     <= 1'b0;
      thermal_shutdown_q  <= 1'b0;
      input_ok_q          <= 1'b0;
    end else begin
      st_q                <= st_d;
      hic_q               <= hic_d;
      high_side_gate_q    <= hs_d;
      low_side_gate_q     <= ls_d;
      power_good_output_q <= pg_d;
      margin_select_q     <= mg_d;
      ot_fault_q          <= otf_c;
      ot_warn_q           <= otw_c;
      dead_time_long_q    <= sp_q[ppc_pkg::SP_DEADTIME_BIT];
      params_locked_q     <= lock_d;
      thermal_shutdown_q  <= tsd_d;
      input_ok_q          <= vin_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  illegal_select_a: assert property (@(posedge mclk) disable iff (!nrst)
    (cmd_wr && cmd_code == ppc_pkg::CMD_CHANNEL_SELECT && cmd_wdata[7] && !cmd_wdata[0])
    |=> $stable(sel_q)) else $error("illegal select changed state");
  tsd_gates_a: assert property (@(posedge mclk) disable iff (!nrst)
    thermal_shutdown_q |=> (high_side_gate_q == 2'b00 && low_side_gate_q == 2'b00))
    else $error("gates on in shutdown");
  lock_sticky_a: assert property (@(posedge mclk) disable iff (!nrst)
    params_locked_q |=> params_locked_q) else $error("lock released");
  pg_off_a: assert property (@(posedge mclk) disable iff (!nrst)
    (st_q[0] != ppc_pkg::CH_RUN) |=> !power_good_output_q[0]) else $error("pg high while off");
  ovp_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    (st_q[0] == ppc_pkg::CH_OVP && !thermal_shutdown_q)
    |=> (low_side_gate_q[0] && !high_side_gate_q[0])) else $error("ovp drive wrong");
  op_reserved_a: assert property (@(posedge mclk) disable iff (!nrst)
    (op_q[0] & ~ppc_pkg::OP_WMASK) == 8'h00) else $error("reserved op bit set");
  two_phase_a: assert property (@(posedge mclk) disable iff (!nrst)
    (two_phase && st_q[0] == ppc_pkg::CH_RUN && st_q[1] == ppc_pkg::CH_RUN && ov_s2_q[0]
     && en[0] && en[1]) |=> (st_q[1] == ppc_pkg::CH_OVP)) else $error("phases split");
  margin_low_a: assert property (@(posedge mclk) disable iff (!nrst)
    (op_q[0][5:2] == 4'h5) |=> (margin_select_q[1:0] == ppc_pkg::MARGIN_LOW))
    else $error("margin low wrong");
  hiccup_a: assert property (@(posedge mclk) disable iff (!nrst)
    (st_q[0] == ppc_pkg::CH_HICCUP && hic_q[0] != 0) |=> (st_q[0] == ppc_pkg::CH_HICCUP))
    else $error("hiccup ended early");
  // Undervoltage with a nonzero response must start the retry wait
  uv_hiccup_a: assert property (@(posedge mclk) disable iff (!nrst)
    (st_q[0] == ppc_pkg::CH_RUN && en[0] && !ov_eff[0] && uv_eff[0] && resp_q[0] != 8'h00)
    |=> (st_q[0] == ppc_pkg::CH_HICCUP)) else $error("undervoltage not handled");
  off_gates_a: assert property (@(posedge mclk) disable iff (!nrst)
    (st_q[0] == ppc_pkg::CH_OFF) |=> (!high_side_gate_q[0] && !low_side_gate_q[0]))
    else $error("gates on while off");
  // A fault on the first channel must not stop the second in dual mode
  ch_isolate_a: assert property (@(posedge mclk) disable iff (!nrst)
    (!two_phase && ov_s2_q[0] && !ov_s2_q[1] && !uv_s2_q[1] && st_q[1] == ppc_pkg::CH_RUN
     && en[1]) |=> (st_q[1] == ppc_pkg::CH_RUN)) else $error("channels not isolated");
endmodule : ppc_top

// *** verif/ppc_host_model.sv ***
`timescale 1ns/1ns
// ****************************************
// Host side command master
// ****************************************
module ppc_host_model (
  input  wire logic        mclk,
  output logic             cmd_wr,
  output logic             cmd_rd,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata,
  input  wire logic [15:0] cmd_rdata_q
);
  initial begin
    cmd_wr    = 1'b0;
    cmd_rd    = 1'b0;
    cmd_code  = 8'ha5;
    cmd_wdata = 16'h5a5a;
  end

  // Idle lines flip so a stale code never passes for a live one
  task automatic release_bus();
    cmd_code  = ~cmd_code;
    cmd_wdata = ~cmd_wdata;
  endtask : release_bus

  // Host programs good-off wider than good-on; no such command reaches this block
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge mclk);
    #2;
    cmd_wr    = 1'b1;
    cmd_code  = code;
    cmd_wdata = data;
    @(posedge mclk);
    #2;
    cmd_wr = 1'b0;
    release_bus();
  endtask : wr

  task automatic rd(input logic [7:0] code, output logic [15:0] data);
    @(posedge mclk);
    #2;
    cmd_rd   = 1'b1;
    cmd_code = code;
    @(posedge mclk);
    #2;
    cmd_rd = 1'b0;
    release_bus();
    @(posedge mclk);
    #2;
    data = cmd_rdata_q;
  endtask : rd
endmodule : ppc_host_model

// *** verif/pmbus_page_operation_fault_control_bench.sv ***
`timescale 1ns/1ns
module pmbus_page_operation_fault_control_bench;
  logic mclk, nrst, cmd_wr, cmd_rd, two_phase, dead, lock, tsd, in_ok;
  logic [7:0]  cmd_code, jt;
  logic [15:0] cmd_wdata, rdata, vin, von, voff, ts, rv;
  logic [1:0]  pins, ov, uv, win, ssd, hon, hs, ls, pg, otf, otw;
  logic [3:0]  marg;
  int          n_errors, cmp_count;
  localparam logic [39:0] MCODES = {8'h00, 8'h14, 8'h18, 8'h24, 8'h28};
  localparam logic [9:0]  MEXP   = 10'b00_01_01_10_10;

  ppc_host_model u_host (.mclk(mclk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
                         .cmd_wdata(cmd_wdata), .cmd_rdata_q(rdata));
  ppc_top #(.HICCUP_CYC(10)) u_dut (.mclk(mclk), .nrst(nrst), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata_q(rdata),
    .two_phase(two_phase), .channel_control_pin(pins), .input_voltage_mv(vin),
    .input_turn_on_threshold(von), .input_turn_off_threshold(voff), .ov_detect(ov),
    .uv_detect(uv), .in_good_on_window(win), .soft_start_done(ssd), .honour_on_bit(hon),
    .junction_temp_c(jt), .temperature_sense_input(ts), .high_side_gate_q(hs),
    .low_side_gate_q(ls), .power_good_output_q(pg), .margin_select_q(marg),
    .ot_fault_q(otf), .ot_warn_q(otw), .dead_time_long_q(dead), .params_locked_q(lock),
    .thermal_shutdown_q(tsd), .input_ok_q(in_ok));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : cyc

  task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp);
    u_host.rd(code, rv);
    chk(rv, exp);
  endtask : rd_chk

  task automatic summarize();
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize

  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    #500000;
    n_errors++;
    summarize();
  end

  // ****************************************
  // Command sequences
  // ****************************************
  initial begin
    {nrst, two_phase, ov, uv, ssd} = '0;
    {pins, win, hon} = 6'h3f;
    {vin, von, voff} = {16'd12000, 16'd10000, 16'd8000};
    jt = 8'd25;
    ts = 16'h2020;
    repeat (3) @(posedge mclk);
    #2;
    nrst = 1'b1;
    chk(16'({hs, ls}), 16'h0);
    rd_chk(8'h01, 16'h0);
    rd_chk(8'h00, 16'h0);
    chk(16'(in_ok), 16'h1);
    vin = 16'd9000;
    cyc(3);
    chk(16'(in_ok), 16'h1);
    vin = 16'd7000;
    cyc(3);
    chk(16'(in_ok), 16'h0);
    vin = 16'd9000;
    cyc(3);
    chk(16'(in_ok), 16'h0);
    {vin, voff} = {16'd3000, 16'd2000};
    cyc(3);
    chk(16'(in_ok), 16'h0);
    {vin, voff} = {16'd12000, 16'd8000};
    u_host.wr(8'h00, 16'h0001);
    rd_chk(8'h00, 16'h0001);
    u_host.wr(8'h00, 16'h0080);
    rd_chk(8'h00, 16'h0001);
    u_host.wr(8'h00, 16'h00ff);
    rd_chk(8'h00, 16'h0081);
    u_host.wr(8'h01, 16'h0080);
    u_host.wr(8'h00, 16'h0001);
    u_host.wr(8'h01, 16'h0000);
    u_host.wr(8'h00, 16'h0081);
    rd_chk(8'h01, 16'h0080);
    cyc(4);
    chk(16'({hs, ls}), 16'h5);
    chk(16'(pg), 16'h0);
    ssd = 2'b11;
    cyc(6);
    chk(16'(pg), 16'h1);
    win = 2'b10;
    cyc(6);
    chk(16'(pg), 16'h0);
    win = 2'b11;
    u_host.wr(8'h00, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      u_host.wr(8'h01, {8'h00, 8'h80 | MCODES[39-8*i -: 8]});
      cyc(2);
      chk(16'(marg[1:0]), 16'(MEXP[9-2*i -: 2]));
      rd_chk(8'h01, {8'h00, 8'h80 | MCODES[39-8*i -: 8]});
    end
    u_host.wr(8'h01, 16'h00ff);
    rd_chk(8'h01, 16'h00bc);
    u_host.wr(8'h01, 16'h0080);
    u_host.wr(8'h00, 16'h0001);
    hon = 2'b01;
    u_host.wr(8'h01, 16'h0080);
    u_host.wr(8'h01, 16'h0000);
    cyc(4);
    chk(16'(hs), 16'h3);
    hon = 2'b11;
    cyc(4);
    chk(16'({hs, pg}), 16'h5);
    u_host.wr(8'h01, 16'h0080);
    cyc(8);
    pins = 2'b01;
    cyc(6);
    chk(16'(hs), 16'h1);
    pins = 2'b11;
    u_host.wr(8'h00, 16'h0000);
    u_host.wr(8'h47, 16'h0001);
    cyc(8);
    uv = 2'b01;
    cyc(6);
    chk(16'({hs, pg[0]}), 16'h4);
    uv = 2'b00;
    cyc(30);
    chk(16'(hs), 16'h3);
    u_host.wr(8'h47, 16'h0000);
    uv = 2'b01;
    cyc(6);
    chk(16'(hs), 16'h3);
    {uv, ov, win} = 6'b00_01_10;
    cyc(6);
    chk(16'({hs, ls}), 16'hb);
    {ov, win} = 4'b00_11;
    cyc(30);
    chk(16'(hs), 16'h3);
    two_phase = 1'b1;
    cyc(2);
    {ov, win} = 4'b01_00;
    cyc(6);
    chk(16'({hs, ls}), 16'h3);
    {ov, two_phase, win} = 5'b00_0_11;
    cyc(30);
    jt = 8'd150;
    cyc(3);
    chk(16'({tsd, hs, ls}), 16'h10);
    jt = 8'd140;
    cyc(3);
    chk(16'(tsd), 16'h1);
    jt = 8'd130;
    cyc(30);
    chk(16'({tsd, hs}), 16'h3);
    rd_chk(8'h4f, 16'h007d);
    u_host.wr(8'h4f, 16'h0050);
    u_host.wr(8'h51, 16'h0040);
    ts = 16'h3060;
    cyc(3);
    chk(16'({otf, otw}), 16'h5);
    ts = 16'h2020;
    cyc(3);
    chk(16'({otf, otw}), 16'h0);
    u_host.wr(8'hd0, 16'hfffd);
    rd_chk(8'hd0, 16'h3ffd);
    chk(16'({dead, lock}), 16'h2);
    u_host.wr(8'hd0, 16'h0002);
    cyc(2);
    chk(16'({dead, lock}), 16'h1);
    u_host.wr(8'h4f, 16'h0011);
    rd_chk(8'h4f, 16'h0050);
    rd_chk(8'h99, 16'h0000);
    summarize();
  end
endmodule : pmbus_page_operation_fault_control_bench
